// [rtl/field_access_register_bank.sv]
/*
 * Register bank demonstrating every field access kind on a simple
 * request/acknowledge bus. One answer per request taken while clkEn is high, one cycle later.
 * Assumes requests from logic on core_clk; hardware event/status inputs
 * are same-domain. Hardware sets win over software clears.
 */
`timescale 1ns/1ps
module field_access_register_bank
    import field_access_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clkEn,
    input  field_access_pkg::bus_req_t      req,
    input  wire logic [15:0]                hwStatus,
    input  wire logic [15:0]                hwEvent,
    output field_access_pkg::bus_rsp_t      rsp,
    output logic [15:0]                     ctrlOut,
    output logic [15:0]                     enaOut,
    output logic                            cmdPulse
);
    import field_access_pkg::*;

    typedef logic [DATA_W-1:0] regArray_t [NUM_REGS];

    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] regs;
        bus_rsp_t                        rsp;
        logic                            cmd;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    decode_t dec;
    access_t kinds [NUM_REGS][DATA_W];
    logic [DATA_W-1:0] rstVals [NUM_REGS];
    logic [DATA_W-1:0] nxtVals [NUM_REGS];
    logic [DATA_W-1:0] rViews  [NUM_REGS];
    logic [NUM_REGS-1:0] wrSel;
    logic [NUM_REGS-1:0] rdSel;

    function automatic access_t kindOf(input int r, input int b);
        if (b >= 16 && r != 6)
            kindOf = ACC_RSVD;
        else
            case (r)
                0:       kindOf = (b < 8) ? ACC_RW : ACC_KEEP;
                1:       kindOf = ACC_RO;
                2:       kindOf = ACC_RDCLR;
                3:       kindOf = ACC_W1CLR;
                4:       kindOf = ACC_WO;
                5:       kindOf = (b < 8) ? ACC_W0ONLY : ACC_W1ONLY;
                6:       kindOf = (b < 16) ? ACC_W0SET : ACC_RDSET;
                default: kindOf = ACC_RW;
            endcase
    endfunction

    always_comb
    begin
        for (int r = 0; r < NUM_REGS; r++)
            for (int b = 0; b < DATA_W; b++)
                kinds[r][b] = kindOf(r, b);
    end

    assign rstVals[0] = RST_CTRL;
    assign rstVals[1] = RST_STATUS;
    assign rstVals[2] = RST_FLAGS;
    assign rstVals[3] = RST_EVSET;
    assign rstVals[4] = RST_CMD;
    assign rstVals[5] = RST_ENA;
    assign rstVals[6] = RST_LOCK;
    assign rstVals[7] = RST_SEMA;

    // Map and reset table are written for eight 32-bit registers
    if (NUM_REGS != 8 || DATA_W != 32 || IDX_W != 3)
    begin : gBadCfg
        $error("register bank is built for eight 32-bit registers only");
    end

    addr_decoder addr_decoder_inst (
        .addr (req.addr),
        .dec  (dec)
    );

    // One-hot strobes for the addressed register
    always_comb
    begin
        wrSel = '0;
        rdSel = '0;
        if (req.sel && dec.hit)
        begin
            wrSel[dec.idx] = req.wr;
            rdSel[dec.idx] = !req.wr;
        end
    end

    for (genvar g = 0; g < NUM_REGS; g++)
    begin : gBit
        field_bit_update #(.WIDTH(DATA_W)) field_bit_update_inst (
            .cur    (st_r.regs[g]),
            .rstVal (rstVals[g]),
            .wdata  (req.wdata),
            .wrStb  (wrSel[g]),
            .rdStb  (rdSel[g]),
            .kind   (kinds[g]),
            .nxt    (nxtVals[g]),
            .rview  (rViews[g])
        );
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rsp = '0;
        st_nxt.cmd = 1'b0;
        for (int r = 0; r < NUM_REGS; r++)
            st_nxt.regs[r] = nxtVals[r];
        // Live status, read only
        st_nxt.regs[1] = {16'h0000, hwStatus};
        // Hardware events set after any clear so they are not lost
        st_nxt.regs[2][15:0] = nxtVals[2][15:0] | hwEvent;
        st_nxt.regs[3][15:0] = nxtVals[3][15:0] | hwEvent;
        if (req.sel)
        begin
            st_nxt.rsp.ack = 1'b1;
            st_nxt.rsp.err = !dec.hit;
            if (!req.wr && dec.hit)
                st_nxt.rsp.rdata = rViews[dec.idx];
            if (req.wr && dec.hit && dec.idx == IDX_W'(4))
                st_nxt.cmd = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st_r.regs[0] <= RST_CTRL;
            st_r.regs[1] <= RST_STATUS;
            st_r.regs[2] <= RST_FLAGS;
            st_r.regs[3] <= RST_EVSET;
            st_r.regs[4] <= RST_CMD;
            st_r.regs[5] <= RST_ENA;
            st_r.regs[6] <= RST_LOCK;
            st_r.regs[7] <= RST_SEMA;
            st_r.rsp <= '0;
            st_r.cmd <= 1'b0;
        end
        else if (clkEn)
            st_r <= st_nxt;
    end

    assign rsp = st_r.rsp;
    assign ctrlOut = st_r.regs[0][15:0];
    assign enaOut = st_r.regs[5][15:0];
    assign cmdPulse = st_r.cmd;

    // Kind and status checks
    AST_RDCLR_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && req.sel && !req.wr && dec.hit && dec.idx == IDX_W'(2) && hwEvent == 16'h0000
        |=> st_r.regs[2] == 32'h0000_0000)
        else $error("read_to_clear register not cleared");

    AST_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r.regs[0][31:16] == 16'h0000 && st_r.regs[5][31:16] == 16'h0000)
        else $error("reserved bits changed");

    AST_RW_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && req.sel && req.wr && dec.hit && dec.idx == IDX_W'(0)
        |=> ctrlOut[7:0] == $past(req.wdata[7:0]))
        else $error("read/write field not loaded");

    AST_W1C: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && req.sel && req.wr && dec.hit && dec.idx == IDX_W'(3) && hwEvent == 16'h0000
        |=> (st_r.regs[3][15:0] & $past(req.wdata[15:0])) == 16'h0000)
        else $error("write_one_to_clear bit still set");

    AST_RDSET_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && req.sel && !req.wr && dec.hit && dec.idx == IDX_W'(6)
        |=> st_r.regs[6][31:16] == 16'hFFFF)
        else $error("read_to_set field not set");

    AST_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && req.sel |=> rsp.ack && rsp.err == !$past(dec.hit))
        else $error("request not answered");

    AST_RO_STATUS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn |=> st_r.regs[1][15:0] == $past(hwStatus))
        else $error("read-only status not tracking");

    AST_W0ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && !(req.sel && req.wr && dec.hit && dec.idx == IDX_W'(5))
        |=> $stable(enaOut))
        else $error("enable field changed without write");

    // Named steps of the access-kind checks
    sequence sFlagsRead;
        clkEn && rdSel[2];
    endsequence

    sequence sLockRead;
        clkEn && rdSel[6];
    endsequence

    sequence sCmdWrite;
        clkEn && wrSel[4];
    endsequence

    sequence sCmdQuiet;
        clkEn && !wrSel[4];
    endsequence

    AST_RDCLR_RETURNS: assert property (@(posedge core_clk) disable iff (!rst_n)
        sFlagsRead
        |=> rsp.rdata[15:0] == $past(st_r.regs[2][15:0]))
        else $error("read_to_clear value not returned");

    AST_RDCLR_EVENT_WINS: assert property (@(posedge core_clk) disable iff (!rst_n)
        sFlagsRead
        |=> st_r.regs[2][15:0] == $past(hwEvent))
        else $error("read_to_clear lost an event of the same cycle");

    AST_RDCLR_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && wrSel[2] && hwEvent == 16'h0000
        |=> $stable(st_r.regs[2]))
        else $error("read_to_clear field changed by a write");

    AST_RDSET_RETURNS: assert property (@(posedge core_clk) disable iff (!rst_n)
        sLockRead
        |=> rsp.rdata[31:16] == $past(st_r.regs[6][31:16]))
        else $error("read_to_set value not returned");

    AST_RDSET_STICKS: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r.regs[6][31:16] == 16'hFFFF
        |=> st_r.regs[6][31:16] == 16'hFFFF)
        else $error("read_to_set field fell back");

    AST_RDSET_WRITE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && wrSel[6]
        |=> st_r.regs[6][31:16] == $past(st_r.regs[6][31:16]))
        else $error("read_to_set field changed by a write");

    AST_W0SET_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && wrSel[6]
        |=> st_r.regs[6][15:0] == ($past(st_r.regs[6][15:0]) | ~$past(req.wdata[15:0])))
        else $error("write_zero_to_set result wrong");

    AST_W1ONLY_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && wrSel[5]
        |=> enaOut[15:8] == ($past(enaOut[15:8]) | $past(req.wdata[15:8])))
        else $error("write_one_only result wrong");

    AST_W0ONLY_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && wrSel[5]
        |=> enaOut[7:0] == ($past(enaOut[7:0]) & $past(req.wdata[7:0])))
        else $error("write_zero_only result wrong");

    AST_WO_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        sCmdWrite
        |=> cmdPulse && st_r.regs[4][15:0] == $past(req.wdata[15:0]))
        else $error("write-only field not loaded");

    AST_CMD_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n)
        sCmdWrite ##1 sCmdQuiet
        |=> !cmdPulse)
        else $error("command pulse longer than one cycle");

    AST_W1C_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && wrSel[3] && hwEvent == 16'h0000
        |=> st_r.regs[3][15:0] == ($past(st_r.regs[3][15:0]) & ~$past(req.wdata[15:0])))
        else $error("write_one_to_clear result wrong");

    AST_EVENT_WINS: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn
        |=> (st_r.regs[2][15:0] & st_r.regs[3][15:0] & $past(hwEvent)) == $past(hwEvent))
        else $error("event lost against a clear");

    AST_RW_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && rdSel[7]
        |=> rsp.rdata == $past(st_r.regs[7]))
        else $error("read/write value not returned");

    AST_RSVD_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && rdSel[0]
        |=> rsp.rdata[31:16] == RST_CTRL[31:16])
        else $error("reserved bits did not read their reset value");

    AST_ERR_NO_DATA: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && req.sel && !dec.hit
        |=> rsp.err && rsp.rdata == 32'h0000_0000)
        else $error("unmapped access not flagged");

    AST_IDLE_NO_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && !req.sel
        |=> !rsp.ack)
        else $error("answer without request");

    AST_RSVD_UPPER: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r.regs[2][31:16] == RST_FLAGS[31:16]
        && st_r.regs[3][31:16] == RST_EVSET[31:16]
        && st_r.regs[4][31:16] == RST_CMD[31:16])
        else $error("reserved bits left their reset value");
endmodule // field_access_register_bank

// [rtl/field_access_pkg.sv]
/*
 * Constants, types and access-kind encoding for a generic field access register bank.
 * Assumes one system clock and a synchronous active-low reset in every user.
 */
// Functional notes
// - Reserved static field reads its reset value; writes ignored.
// - Read-only field returns live value; writes have no effect.
// - Write-only field loads writes; read data is undefined.
// - Read/write field returns value; write replaces it.
// - read_to_clear returns value, then clears to 0; writes ignored.
// - read_to_set returns value, then sets to 1; writes ignored.
// - write_zero_only: writing 0 clears bit, writing 1 leaves it.
// - write_one_only: writing 1 sets bit, writing 0 leaves it.
// - write_one_to_clear: writing 1 clears bit, writing 0 nothing.
// - write_zero_to_set: writing 0 sets bit, writing 1 nothing.
// - Registers are 32 bits wide.
// - Register absolute address is base address plus offset.
// - Bit 0 is the least significant bit.
package field_access_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int NUM_REGS = 8;
    localparam int IDX_W = 3;

    localparam logic [ADDR_W-1:0] BASE_ADDR = 32'h4000_0000;

    // Access kinds, one per bit
    typedef enum logic [3:0] {
        ACC_RSVD       = 4'h0,
        ACC_KEEP       = 4'h1,
        ACC_RO         = 4'h2,
        ACC_WO         = 4'h3,
        ACC_RW         = 4'h4,
        ACC_RDCLR      = 4'h5,
        ACC_RDSET      = 4'h6,
        ACC_W0ONLY     = 4'h7,
        ACC_W1ONLY     = 4'h8,
        ACC_W1CLR      = 4'h9,
        ACC_W0SET      = 4'hA
    } access_t;

    // Register offsets, byte addresses from the base
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] OFF_FLAGS  = 32'h0000_0008;
    localparam logic [ADDR_W-1:0] OFF_EVSET  = 32'h0000_000C;
    localparam logic [ADDR_W-1:0] OFF_CMD    = 32'h0000_0010;
    localparam logic [ADDR_W-1:0] OFF_ENA    = 32'h0000_0014;
    localparam logic [ADDR_W-1:0] OFF_LOCK   = 32'h0000_0018;
    localparam logic [ADDR_W-1:0] OFF_SEMA   = 32'h0000_001C;

    // Reset values
    localparam logic [DATA_W-1:0] RST_CTRL   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_STATUS = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_FLAGS  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_EVSET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_CMD    = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_ENA    = 32'h0000_FFFF;
    localparam logic [DATA_W-1:0] RST_LOCK   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_SEMA   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RSVD_PATTERN = 32'h0000_0000;

    // Bus request and answer
    typedef struct packed {
        logic              sel;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic              ack;
        logic              err;
        logic [DATA_W-1:0] rdata;
    } bus_rsp_t;

    typedef struct packed {
        logic              hit;
        logic [IDX_W-1:0]  idx;
    } decode_t;

endpackage

// [rtl/addr_decoder.sv]
/*
 * Address decoder: maps an absolute address onto a register index.
 * Assumes word-aligned offsets from BASE_ADDR and combinational use.
 */
`timescale 1ns/1ps
module addr_decoder
    import field_access_pkg::*;
(
    input  wire logic [ADDR_W-1:0]          addr,
    output field_access_pkg::decode_t       dec
);
    import field_access_pkg::*;

    function automatic logic [ADDR_W-1:0] offsetOf(input int i);
        case (i)
            0:       offsetOf = OFF_CTRL;
            1:       offsetOf = OFF_STATUS;
            2:       offsetOf = OFF_FLAGS;
            3:       offsetOf = OFF_EVSET;
            4:       offsetOf = OFF_CMD;
            5:       offsetOf = OFF_ENA;
            6:       offsetOf = OFF_LOCK;
            default: offsetOf = OFF_SEMA;
        endcase
    endfunction

    always_comb
    begin
        dec = '0;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (addr == BASE_ADDR + offsetOf(i))
            begin
                dec.hit = 1'b1;
                dec.idx = IDX_W'(i);
            end
        end
    end
endmodule // addr_decoder

// [rtl/field_bit_update.sv]
/*
 * Per-bit next-value logic for every access kind.
 * Assumes one-cycle read and write strobes from the bank.
 */
`timescale 1ns/1ps
module field_bit_update
    import field_access_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input  wire logic [WIDTH-1:0]           cur,
    input  wire logic [WIDTH-1:0]           rstVal,
    input  wire logic [WIDTH-1:0]           wdata,
    input  wire logic                       wrStb,
    input  wire logic                       rdStb,
    input  field_access_pkg::access_t       kind [WIDTH],
    output logic [WIDTH-1:0]                nxt,
    output logic [WIDTH-1:0]                rview
);
    import field_access_pkg::*;

    if (WIDTH < 1)
    begin : gBadWidth
        $error("field_bit_update needs a WIDTH of at least one bit");
    end

    always_comb
    begin
        for (int b = 0; b < WIDTH; b++)
        begin
            nxt[b] = cur[b];
            rview[b] = cur[b];
            case (kind[b])
                ACC_RSVD:
                begin
                    nxt[b] = rstVal[b];
                    rview[b] = rstVal[b];
                end
                ACC_RO:   nxt[b] = cur[b];
                ACC_WO:
                begin
                    if (wrStb) nxt[b] = wdata[b];
                    rview[b] = 1'b0;
                end
                ACC_RW, ACC_KEEP:
                    if (wrStb) nxt[b] = wdata[b];
                ACC_RDCLR: if (rdStb) nxt[b] = 1'b0;
                ACC_RDSET: if (rdStb) nxt[b] = 1'b1;
                ACC_W0ONLY: if (wrStb && !wdata[b]) nxt[b] = 1'b0;
                ACC_W1ONLY: if (wrStb && wdata[b]) nxt[b] = 1'b1;
                ACC_W1CLR:  if (wrStb && wdata[b]) nxt[b] = 1'b0;
                ACC_W0SET:  if (wrStb && !wdata[b]) nxt[b] = 1'b1;
                default:  nxt[b] = cur[b];
            endcase
        end
    end
endmodule // field_bit_update

// [test/tb_field_access_register_bank.sv]
/*
 * Self-checking bench for the field access register bank.
 * Assumes the bank answers each request made while clkEn is high one cycle later.
 */
`timescale 1ns/1ps
module tb_field_access_register_bank;
    import field_access_pkg::*;

    logic        core_clk;
    logic        rst_n;
    logic        clkEn;
    bus_req_t    req;
    logic [15:0] hwStatus;
    logic [15:0] hwEvent;
    bus_rsp_t    rsp;
    bus_rsp_t    lastRsp;
    logic [15:0] ctrlOut;
    logic [15:0] enaOut;
    logic        cmdPulse;
    int          n_fail;
    int          total_checks;
    int          cycles;
    int          pulses;

    field_access_register_bank field_access_register_bank_inst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .req      (req),
        .hwStatus (hwStatus),
        .hwEvent  (hwEvent),
        .rsp      (rsp),
        .ctrlOut  (ctrlOut),
        .enaOut   (enaOut),
        .cmdPulse (cmdPulse)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cmdPulse === 1'b1)
            pulses++;
        if (cycles == 3000)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask

    // One request, answer taken one cycle later
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        #1;
        req.sel = 1'b1;
        req.wr = wr;
        req.addr = addr;
        req.wdata = wd;
        @(posedge core_clk);
        #1;
        lastRsp = rsp;
        req.sel = 1'b0;
    endtask

    task automatic rdChk(input string what, input logic [ADDR_W-1:0] off, input logic [31:0] exp);
        access(1'b0, BASE_ADDR + off, 32'h0000_0000);
        check({what, " ack"}, {31'h0, lastRsp.ack}, 32'h0000_0001);
        check(what, lastRsp.rdata, exp);
    endtask

    task automatic testReset();
        check("ctrlOut", {16'h0, ctrlOut}, 32'h0000_0000);
        check("enaOut", {16'h0, enaOut}, 32'h0000_FFFF);
        rdChk("ena reset", OFF_ENA, RST_ENA);
    endtask

    task automatic testRw();
        access(1'b1, BASE_ADDR + OFF_CTRL, 32'hFFFF_FFFF);
        check("ctrlOut all", {16'h0, ctrlOut}, 32'h0000_FFFF);
        rdChk("ctrl reserved", OFF_CTRL, 32'h0000_FFFF);
        access(1'b1, BASE_ADDR + OFF_CTRL, {16'h0, lastRsp.rdata[15:8], 8'h01});
        check("ctrlOut bit0", {16'h0, ctrlOut}, 32'h0000_FF01);
        access(1'b1, BASE_ADDR + OFF_SEMA, 32'hA5A5_5A5A);
        rdChk("sema", OFF_SEMA, 32'h0000_5A5A);
    endtask

    task automatic testStatus();
        hwStatus = 16'h1234;
        access(1'b1, BASE_ADDR + OFF_STATUS, 32'hFFFF_FFFF);
        rdChk("status", OFF_STATUS, 32'h0000_1234);
    endtask

    task automatic testEvents();
        hwEvent = 16'h0081;
        @(posedge core_clk);
        #1;
        hwEvent = 16'h0000;
        access(1'b1, BASE_ADDR + OFF_FLAGS, 32'hFFFF_FFFF);
        rdChk("flags first", OFF_FLAGS, 32'h0000_0081);
        rdChk("flags second", OFF_FLAGS, 32'h0000_0000);
        // Event in the very cycle of the clearing read
        @(posedge core_clk);
        #1;
        req.sel = 1'b1;
        req.wr = 1'b0;
        req.addr = BASE_ADDR + OFF_FLAGS;
        hwEvent = 16'h0004;
        @(posedge core_clk);
        #1;
        check("flags race read", rsp.rdata, 32'h0000_0000);
        req.sel = 1'b0;
        hwEvent = 16'h0000;
        rdChk("flags event kept", OFF_FLAGS, 32'h0000_0004);
        access(1'b1, BASE_ADDR + OFF_EVSET, 32'h0000_0001);
        rdChk("evset", OFF_EVSET, 32'h0000_0084);
    endtask

    task automatic testCmd();
        pulses = 0;
        access(1'b1, BASE_ADDR + OFF_CMD, 32'h0000_00FF);
        repeat (3) @(posedge core_clk);
        #1;
        check("cmd pulses", pulses, 32'h0000_0001);
        rdChk("cmd read", OFF_CMD, 32'h0000_0000);
    endtask

    task automatic testEna();
        access(1'b1, BASE_ADDR + OFF_ENA, 32'h0000_00F0);
        check("enaOut", {16'h0, enaOut}, 32'h0000_FFF0);
        access(1'b1, BASE_ADDR + OFF_ENA, 32'h0000_000F);
        rdChk("ena", OFF_ENA, 32'h0000_FF00);
    endtask

    task automatic testLock();
        rdChk("lock first", OFF_LOCK, 32'h0000_0000);
        rdChk("lock second", OFF_LOCK, 32'hFFFF_0000);
        access(1'b1, BASE_ADDR + OFF_LOCK, 32'h0000_FF00);
        rdChk("lock", OFF_LOCK, 32'hFFFF_00FF);
    endtask

    task automatic testErrAndEnable();
        access(1'b0, BASE_ADDR + 32'h0000_0020, 32'h0000_0000);
        check("unmapped err", {31'h0, lastRsp.err}, 32'h0000_0001);
        check("unmapped data", lastRsp.rdata, 32'h0000_0000);
        access(1'b1, OFF_SEMA, 32'h0000_0000);
        check("no base err", {31'h0, lastRsp.err}, 32'h0000_0001);
        // Idle edge first, so the frozen answer is not a stale ack
        @(posedge core_clk);
        #1;
        clkEn = 1'b0;
        access(1'b1, BASE_ADDR + OFF_SEMA, 32'h0000_0000);
        check("frozen ack", {31'h0, lastRsp.ack}, 32'h0000_0000);
        clkEn = 1'b1;
        rdChk("sema kept", OFF_SEMA, 32'h0000_5A5A);
    endtask

    initial
    begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        req = '0;
        hwStatus = 16'h0000;
        hwEvent = 16'h0000;
        n_fail = 0;
        total_checks = 0;
        cycles = 0;
        pulses = 0;
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        testReset();
        testRw();
        testStatus();
        testEvents();
        testCmd();
        testEna();
        testLock();
        testErrAndEnable();
        summarize();
    end
endmodule // tb_field_access_register_bank
